/* File: rtl/secondary_bar_pkg.sv */
package secondary_bar_pkg;

   // Register byte addresses on the Wishbone port
   localparam logic [11:0] OFS_CSR_IO_WIN = 12'h054;
   localparam logic [11:0] OFS_WIN_ONE = 12'h058;
   localparam logic [11:0] OFS_PAGED_WIN = 12'h05C;
   localparam logic [11:0] OFS_LUT_FIRST = 12'h100;
   localparam logic [11:0] OFS_LUT_LAST = 12'h1FF;

   // Field positions
   localparam int SPACE_IO_BIT = 0;
   localparam int ATTR_TYPE_LSB = 1;
   localparam int ATTR_PREF_BIT = 3;
   localparam int CSR_BASE_LSB = 8;
   localparam int WIN_ONE_BASE_LSB = 6;
   localparam int WIN_ONE_MEM_MIN_LSB = 12;
   localparam int WIN_ONE_IO_MAX_LSB = 8;
   localparam int PAGED_BASE_MIN_LSB = 14;
   localparam int SETUP_ENABLE_BIT = 31;
   localparam int PAGE_IDX_BITS = 6;
   localparam int PAGE_COUNT = 64;
   localparam int LUT_VALID_BIT = 0;

   // Page size code: page is 2**(8+code) bytes, window is 64 pages
   localparam logic [4:0] PAGE_CODE_MAX = 5'h11;

   // Values after reset
   localparam logic [31:0] CSR_IO_WIN_RST = 32'h0000_0001;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam logic [31:0] LUT_RST = 32'h0000_0000;

   // Answer of the slave for unmapped reads
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Ones from bit lsb upward
   function automatic logic [31:0] upper_mask(input logic [5:0] lsb);
      upper_mask = 32'hFFFF_FFFF << lsb;
   endfunction

   // Merge write data into a register under byte enables and a writable mask
   function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel,
                                              input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
      merge_write = (old_val & ~m) | (wdat & m);
   endfunction

endpackage

/* File: rtl/window_match.sv */
`timescale 1ns/1ps
`default_nettype none

module window_match (
   input wire logic i_enable,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_base,
   input wire logic [31:0] i_mask,
   output logic o_hit
);
   // A zero base field decodes nothing, whatever the mask
   always_comb begin
      o_hit = i_enable && ((i_base & i_mask) != 32'h0000_0000) &&
              ((i_addr & i_mask) == (i_base & i_mask));
   end

endmodule

`default_nettype wire

/* File: rtl/secondary_bar_decode.sv */
// Function
// - CSR I/O window bit 0 reads one after reset; bits 7:1 read zero.
// - CSR I/O base in bits 31:8, 256-byte window, resets to zero.
// - Window one reports space, decode width and prefetch read-only; reset zero.
// - Window one size and type follow its externally loaded setup register.
// - Window one spans 4KB to 2GB for memory, 64B to 256B for I/O.
// - Window one hits translate directly through the translated-base register.
// - A base bit is writable only where the setup bit is one; I/O window one bits 31:8 always are.
// - Upstream windows decode nothing while base is zero; bases reset zero.
// - Paged window decodes 32-bit only; type reads 00, bits 13:4 read zero.
// - Paged window decodes memory only, 16KB to 2GB, base in 31:14.
// - Paged window splits into 64 pages sized by the forwarding control.
// - Page disabled when lookup entry bit 0 is zero; table at 100h-1FFh.
// - Writable paged base bits vary with configured page size.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

module secondary_bar_decode (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [11:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Setup state held by the bridge's main logic
   input wire logic [31:0] i_win_one_setup,
   input wire logic [31:0] i_win_one_xlat_base,
   input wire logic [4:0] i_page_size_code,
   // Secondary bus address phase
   input wire logic i_sec_valid,
   input wire logic i_sec_is_io,
   input wire logic [31:0] i_sec_addr,
   output logic o_claim_csr,
   output logic o_claim_up,
   output logic [31:0] o_up_addr
);
   import secondary_bar_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Local helpers

   // Word compare on the bus address; bits 1:0 pick bytes, not registers
   function automatic logic word_hit(input logic [11:0] adr, input logic [11:0] ofs);
      word_hit = (adr[11:2] == ofs[11:2]);
   endfunction

   // Upper bits from a translated base, the rest from the bus address
   // Shared by window one and the pages, so both splice the same way
   function automatic logic [31:0] splice_addr(input logic [31:0] upper,
                                               input logic [31:0] lower,
                                               input logic [31:0] upper_bits);
      splice_addr = (upper & upper_bits) | (lower & ~upper_bits);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register state

   // Stored base bits survive a shrink of the writable mask: they read zero
   // and drop out of decode, and come back if the mask widens again, so
   // software should rewrite the bases after the setup is reloaded.
   logic [31:0] csr_base_r;
   logic [31:0] csr_base_nxt;
   logic [31:0] win_one_base_r;
   logic [31:0] win_one_base_nxt;
   logic [31:0] paged_base_r;
   logic [31:0] paged_base_nxt;
   // Lookup table, one word per page of the paged window
   logic [31:0] lut_r [PAGE_COUNT];
   logic [31:0] lut_nxt [PAGE_COUNT];
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic ack_r;
   logic ack_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Window sizing from setup

   // Decode masks; a one marks a base bit that takes part in decode
   logic win_one_io;
   logic win_one_en;
   logic [31:0] win_one_legal;
   logic [31:0] win_one_mask;
   logic [4:0] page_code;
   logic [5:0] paged_lsb;
   logic [5:0] page_lsb;
   logic [31:0] paged_mask;
   logic [31:0] page_off_mask;
   logic [31:0] csr_mask;

   // Setup and page size are same-clock levels from the bridge's main logic;
   // a change acts on decode at once, so loading should end before bases
   // are written.
   // Setup bits give space type, and which base bits exist
   always_comb begin
      win_one_io = i_win_one_setup[SPACE_IO_BIT];
      win_one_en = i_win_one_setup[SETUP_ENABLE_BIT];
      if (win_one_io) begin
         // I/O sizes stop at 256B, so bits 31:8 are always base bits
         // Bits 7:6 stay writable only where setup asks, giving 64B to 256B
         win_one_legal = upper_mask(6'(WIN_ONE_BASE_LSB));
      end else begin
         // Memory sizes start at 4KB, so bits 11:6 never take a base
         win_one_legal = upper_mask(6'(WIN_ONE_MEM_MIN_LSB));
      end
      // Setup bit 31 doubles as enable and as the top writable base bit
      win_one_mask = i_win_one_setup & win_one_legal;
      if (win_one_io) begin
         win_one_mask = win_one_mask | upper_mask(6'(WIN_ONE_IO_MAX_LSB));
      end
      // CSR window is fixed at 256 bytes, so its mask never changes
      csr_mask = upper_mask(6'(CSR_BASE_LSB));
   end

   // Page size code clamped so the window never passes 2GB
   // Codes above the clamp would shift the base field off bit 31 and leave
   // a window with no base bits at all, which could never be placed.
   always_comb begin
      if (i_page_size_code > PAGE_CODE_MAX) begin
         page_code = PAGE_CODE_MAX;
      end else begin
         page_code = i_page_size_code;
      end
      paged_lsb = 6'(PAGED_BASE_MIN_LSB) + {1'b0, page_code};
      page_lsb = paged_lsb - 6'(PAGE_IDX_BITS);
      paged_mask = upper_mask(paged_lsb);
      // Offset mask keeps the bits below the page index for translation
      page_off_mask = ~upper_mask(page_lsb);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   // Request taken only while ack is low
   logic bus_req;
   logic hit_csr;
   logic hit_one;
   logic hit_paged;
   logic hit_lut;
   logic [5:0] lut_idx;
   logic [31:0] csr_rd;
   logic [31:0] one_rd;
   logic [31:0] paged_rd;

   // Every request is answered one cycle after it is taken, mapped or not;
   // unmapped words read zero and drop writes, so a stray access never hangs.
   // Read images; window one attribute fields come from setup, CSR bit 0 reads one, others are zero
   // Attribute bits are not storage, so writes to them can never stick
   always_comb begin
      csr_rd = (csr_base_r & csr_mask) | CSR_IO_WIN_RST;
      one_rd = win_one_base_r & win_one_mask;
      one_rd[SPACE_IO_BIT] = i_win_one_setup[SPACE_IO_BIT];
      one_rd[ATTR_TYPE_LSB +: 2] = i_win_one_setup[ATTR_TYPE_LSB +: 2];
      one_rd[ATTR_PREF_BIT] = i_win_one_setup[ATTR_PREF_BIT];
      // Memory space, 32-bit type, bits 13:4 stay zero
      paged_rd = paged_base_r & paged_mask;
   end

   // Address decode; ack comes one cycle after the request and drops after
   // Ack gates the request, so a strobe held across ack writes once only
   always_comb begin
      bus_req = i_wb_cyc && i_wb_stb && !ack_r;
      hit_csr = word_hit(i_wb_adr, OFS_CSR_IO_WIN);
      hit_one = word_hit(i_wb_adr, OFS_WIN_ONE);
      hit_paged = word_hit(i_wb_adr, OFS_PAGED_WIN);
      hit_lut = (i_wb_adr >= OFS_LUT_FIRST) && (i_wb_adr <= OFS_LUT_LAST);
      lut_idx = i_wb_adr[7:2];
      ack_nxt = bus_req;
      rdat_nxt = rdat_r;
      if (bus_req) begin
         if (hit_csr) begin
            rdat_nxt = csr_rd;
         end else if (hit_one) begin
            rdat_nxt = one_rd;
         end else if (hit_paged) begin
            rdat_nxt = paged_rd;
         end else if (hit_lut) begin
            rdat_nxt = lut_r[lut_idx];
         end else begin
            rdat_nxt = UNMAPPED_DATA;
         end
      end
   end

   // Register writes take effect on the request cycle, under byte enables
   // A write lands at the edge that raises ack, so a read right after sees it
   always_comb begin
      csr_base_nxt = csr_base_r;
      win_one_base_nxt = win_one_base_r;
      paged_base_nxt = paged_base_r;
      for (int i = 0; i < PAGE_COUNT; i++) begin
         lut_nxt[i] = lut_r[i];
      end
      if (bus_req && i_wb_we) begin
         if (hit_csr) begin
            csr_base_nxt = merge_write(csr_base_r, i_wb_dat, i_wb_sel, csr_mask);
         end else if (hit_one) begin
            win_one_base_nxt = merge_write(win_one_base_r, i_wb_dat, i_wb_sel,
                                           win_one_mask);
         end else if (hit_paged) begin
            paged_base_nxt = merge_write(paged_base_r, i_wb_dat, i_wb_sel,
                                         paged_mask);
         end else if (hit_lut) begin
            // Table words store the whole value; bit 0 enables the page
            lut_nxt[lut_idx] = merge_write(lut_r[lut_idx], i_wb_dat, i_wb_sel,
                                           32'hFFFF_FFFF);
         end
      end
   end

   // Bus-side flip-flops; the table resets to all pages disabled
   // Only constants in the reset branch, so reset needs no running clock
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         csr_base_r <= BASE_RST;
         win_one_base_r <= BASE_RST;
         paged_base_r <= BASE_RST;
         for (int i = 0; i < PAGE_COUNT; i++) begin
            lut_r[i] <= LUT_RST;
         end
         rdat_r <= UNMAPPED_DATA;
         ack_r <= 1'b0;
      end else begin
         csr_base_r <= csr_base_nxt;
         win_one_base_r <= win_one_base_nxt;
         paged_base_r <= paged_base_nxt;
         for (int i = 0; i < PAGE_COUNT; i++) begin
            lut_r[i] <= lut_nxt[i];
         end
         rdat_r <= rdat_nxt;
         ack_r <= ack_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Secondary address decode and translation

   // Decode is a pure function of the registered bases, the setup and the phase; claims
   // and the translated address leave through flops one cycle later. Only the
   // CSR window answers I/O unconditionally, the paged window never does, and
   // window one follows the space bit of its setup.
   logic csr_hit;
   logic one_hit;
   logic paged_hit;
   logic [5:0] page_idx;
   logic [31:0] page_entry;
   logic page_valid;
   logic claim_csr_r;
   logic claim_csr_nxt;
   logic claim_up_r;
   logic claim_up_nxt;
   logic [31:0] up_addr_r;
   logic [31:0] up_addr_nxt;

   // Own registers: 256 bytes of I/O space at the base
   window_match u_csr_match (
      .i_enable(i_sec_valid && i_sec_is_io),
      .i_addr(i_sec_addr),
      .i_base(csr_base_r),
      .i_mask(csr_mask),
      .o_hit(csr_hit)
   );

   // Window one decodes only the space its setup names
   // An I/O window never catches memory cycles, and the reverse
   window_match u_one_match (
      .i_enable(i_sec_valid && win_one_en && (i_sec_is_io == win_one_io)),
      .i_addr(i_sec_addr),
      .i_base(win_one_base_r),
      .i_mask(win_one_mask),
      .o_hit(one_hit)
   );

   // Paged window never answers I/O cycles
   // Its base bits start at bit 14 plus the page code
   window_match u_paged_match (
      .i_enable(i_sec_valid && !i_sec_is_io),
      .i_addr(i_sec_addr),
      .i_base(paged_base_r),
      .i_mask(paged_mask),
      .o_hit(paged_hit)
   );

   // Page index sits just above the page offset
   // The index moves with the page size; the 6-bit mask keeps it inside the table
   always_comb begin
      page_idx = 6'((i_sec_addr >> page_lsb) & 32'h0000_003F);
      page_entry = lut_r[page_idx];
      page_valid = page_entry[LUT_VALID_BIT];
   end

   // Own registers win over forwarding; window one over the paged window
   // Own registers win so software can always reach them, even when a
   // forwarding window has been placed over the same addresses.
   always_comb begin
      claim_csr_nxt = csr_hit;
      claim_up_nxt = 1'b0;
      up_addr_nxt = up_addr_r;
      if (!csr_hit && one_hit) begin
         claim_up_nxt = 1'b1;
         up_addr_nxt = splice_addr(i_win_one_xlat_base, i_sec_addr, win_one_mask);
      end else if (!csr_hit && paged_hit && page_valid) begin
         claim_up_nxt = 1'b1;
         up_addr_nxt = splice_addr(page_entry, i_sec_addr, ~page_off_mask);
      end
   end

   // Claim is a one-cycle answer to each valid address phase
   // A valid held high on a steady hit keeps the claim up, one per cycle
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         claim_csr_r <= 1'b0;
         claim_up_r <= 1'b0;
         up_addr_r <= BASE_RST;
      end else begin
         claim_csr_r <= claim_csr_nxt;
         claim_up_r <= claim_up_nxt;
         up_addr_r <= up_addr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Flops straight to pins, so the secondary bus sees clean timing
   // whatever depth the decode grows to.
   assign o_wb_dat = rdat_r;
   assign o_wb_ack = ack_r;
   assign o_claim_csr = claim_csr_r;
   assign o_claim_up = claim_up_r;
   assign o_up_addr = up_addr_r;

endmodule

`default_nettype wire

/* File: dv/secondary_bar_decode_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module secondary_bar_checker
   import secondary_bar_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [11:0] i_wb_adr,
   input wire logic [31:0] i_win_one_setup,
   input wire logic i_sec_valid,
   input wire logic i_sec_is_io,
   input wire logic [31:0] i_sec_addr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic o_claim_csr,
   input wire logic o_claim_up,
   input wire logic [31:0] o_up_addr
);
   // Single clock domain
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////
   // Bus answer timing
   ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");
   ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack missing");
   // Fixed bits are judged at the ack that carries the read
   csr_low_bits_a: assert property (o_wb_ack && !$past(i_wb_we) &&
      $past(i_wb_adr) == OFS_CSR_IO_WIN |-> o_wb_dat[7:0] == 8'h01) else $error("csr low");
   attr_mirror_a: assert property (o_wb_ack && !$past(i_wb_we) &&
      $past(i_wb_adr) == OFS_WIN_ONE |-> o_wb_dat[3:0] == $past(i_win_one_setup[3:0]))
      else $error("attr bits");
   paged_low_zero_a: assert property (o_wb_ack && !$past(i_wb_we) &&
      $past(i_wb_adr) == OFS_PAGED_WIN |-> o_wb_dat[13:0] == 14'h0000) else $error("paged low");
   // Decode side
   claim_needs_valid_a: assert property (!i_sec_valid |=> !o_claim_csr && !o_claim_up)
      else $error("claim without phase");
   csr_io_only_a: assert property (i_sec_valid && !i_sec_is_io |=> !o_claim_csr)
      else $error("csr claimed memory");
   offset_pass_a: assert property (o_claim_up |-> o_up_addr[5:0] == $past(i_sec_addr[5:0]))
      else $error("offset lost");
   addr_hold_a: assert property (!o_claim_up |-> $stable(o_up_addr))
      else $error("addr moved");
   cover property (o_claim_csr);
   cover property (o_claim_up);
   cover property (o_wb_ack && $past(i_wb_we));
endmodule
bind secondary_bar_decode secondary_bar_checker u_chk (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
   .i_wb_adr(i_wb_adr), .i_win_one_setup(i_win_one_setup), .i_sec_valid(i_sec_valid),
   .i_sec_is_io(i_sec_is_io), .i_sec_addr(i_sec_addr), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .o_claim_csr(o_claim_csr), .o_claim_up(o_claim_up),
   .o_up_addr(o_up_addr));
`default_nettype wire

/* File: dv/sec_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sec_bus_master (
   input wire logic i_clk_sys,
   output logic o_valid,
   output logic o_is_io,
   output logic [31:0] o_addr
);
   // Idle bus at time zero
   initial begin
      o_valid = 1'b0;
      o_is_io = 1'b0;
      o_addr = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////
   // One address phase of one cycle; released lines show the inverse
   // so a stale address is never taken for a live one
   task automatic phase(input logic io, input logic [31:0] a);
      @(posedge i_clk_sys);
      o_valid <= 1'b1;
      o_is_io <= io;
      o_addr <= a;
      @(posedge i_clk_sys);
      o_valid <= 1'b0;
      o_is_io <= ~io;
      o_addr <= ~a;
   endtask
endmodule
`default_nettype wire

/* File: dv/secondary_bar_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module secondary_bar_decode_tb;
   import secondary_bar_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] setup = 32'h0000_0000;
   logic [31:0] xlat = 32'hABCD_E000;
   logic [4:0] code = 5'h00;
   logic valid;
   logic is_io;
   logic [31:0] saddr;
   logic [31:0] rdat;
   logic [31:0] up_addr;
   logic [31:0] got;
   logic ack;
   logic c_csr;
   logic c_up;
   int err_count = 0;
   int checks = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   secondary_bar_decode u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_win_one_setup(setup), .i_win_one_xlat_base(xlat),
      .i_page_size_code(code), .i_sec_valid(valid), .i_sec_is_io(is_io),
      .i_sec_addr(saddr), .o_claim_csr(c_csr), .o_claim_up(c_up), .o_up_addr(up_addr));
   sec_bus_master u_sec (.i_clk_sys(clk), .o_valid(valid), .o_is_io(is_io), .o_addr(saddr));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Classic cycle; waits for ack as long as it takes, the watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
      chk(n, 32'h0000_0002);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(got, e);
   endtask
   task automatic cfg(input logic [31:0] s, input logic [4:0] c);
      @(posedge clk);
      setup <= s;
      code <= c;
   endtask
   // Claims show one cycle after the phase
   task automatic dec(input logic io, input logic [31:0] a, input logic [1:0] e,
                      input logic [31:0] ea);
      u_sec.phase(io, a);
      #1;
      chk({30'h0, c_csr, c_up}, {30'h0, e});
      if (e[0]) chk(up_addr, ea);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CSR_IO_WIN, 32'h0000_0001);
      rd(OFS_WIN_ONE, 32'h0000_0000);
      rd(OFS_PAGED_WIN, 32'h0000_0000);
      rd(OFS_LUT_FIRST, 32'h0000_0000);
      rd(12'h040, 32'h0000_0000);
      wr(OFS_CSR_IO_WIN, 32'hFFFF_FFFF);
      rd(OFS_CSR_IO_WIN, 32'hFFFF_FF01);
      cfg(32'hFFFF_F008, 5'h00);
      wr(OFS_WIN_ONE, 32'hFFFF_FFFF);
      rd(OFS_WIN_ONE, 32'hFFFF_F008);
      cfg(32'hF000_0000, 5'h00);
      rd(OFS_WIN_ONE, 32'hF000_0000);
      cfg(32'h8000_00C1, 5'h00);
      wr(OFS_WIN_ONE, 32'hFFFF_FFFF);
      rd(OFS_WIN_ONE, 32'hFFFF_FFC1);
      cfg(32'h8000_0001, 5'h00);
      rd(OFS_WIN_ONE, 32'hFFFF_FF01);
      cfg(32'hFFFF_F000, 5'h00);
      wr(OFS_WIN_ONE, 32'h1234_5000);
      dec(1'b0, 32'h1234_5678, 2'b01, 32'hABCD_E678);
      dec(1'b0, 32'h1234_6000, 2'b00, 32'h0000_0000);
      dec(1'b1, 32'h1234_5678, 2'b00, 32'h0000_0000);
      cfg(32'h7FFF_F000, 5'h00);
      dec(1'b0, 32'h1234_5678, 2'b00, 32'h0000_0000);
      cfg(32'hFFFF_F000, 5'h00);
      wr(OFS_WIN_ONE, 32'h0000_0000);
      dec(1'b0, 32'h0000_0678, 2'b00, 32'h0000_0000);
      wr(OFS_CSR_IO_WIN, 32'h0000_1200);
      dec(1'b1, 32'h0000_12AB, 2'b10, 32'h0000_0000);
      dec(1'b0, 32'h0000_12AB, 2'b00, 32'h0000_0000);
      wr(OFS_PAGED_WIN, 32'hFFFF_FFFF);
      rd(OFS_PAGED_WIN, 32'hFFFF_C000);
      cfg(32'hFFFF_F000, 5'h02);
      rd(OFS_PAGED_WIN, 32'hFFFF_0000);
      cfg(32'hFFFF_F000, 5'h00);
      wr(OFS_PAGED_WIN, 32'h0040_0000);
      wr(12'h104, 32'h7777_7701);
      dec(1'b0, 32'h0040_0155, 2'b01, 32'h7777_7755);
      dec(1'b0, 32'h0040_0255, 2'b00, 32'h0000_0000);
      report_and_stop;
   end
   // Watchdog, far beyond the expected run of a few microseconds
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
endmodule
`default_nettype wire
